// ===== rtl/brb_pkg.sv
// Package for the branch record store: register map, field layout, states.
// Assumes an AXI4-Lite master with 32-bit data and one clock domain.
package brb_pkg;

    // ********************************************************************
    // Geometry
    // ********************************************************************
    localparam int          BRB_DEPTH      = 64;
    localparam int          BRB_BANK_SIZE  = 32;
    localparam int          BRB_IDX_W      = 6;
    localparam logic [7:0]  BRB_CAP_CODE   = 8'h40;
    localparam logic [1:0]  BRB_VALID_NONE = 2'h0;
    localparam int          BRB_VALID_LSB  = 0;

    // ********************************************************************
    // Register map (byte addresses)
    // ********************************************************************
    localparam logic [11:0] BRB_A_ID      = 12'h000;
    localparam logic [11:0] BRB_A_CTRL    = 12'h004;
    localparam logic [11:0] BRB_A_STG_SRC = 12'h008;
    localparam logic [11:0] BRB_A_STG_TGT = 12'h00C;
    localparam logic [11:0] BRB_A_STG_INF = 12'h010;
    localparam logic [11:0] BRB_A_CMD     = 12'h014;
    localparam logic [11:0] BRB_A_STAT    = 12'h018;
    localparam logic [11:0] BRB_A_WIN     = 12'h400;
    localparam logic [11:0] BRB_A_WIN_END = 12'h600;

    // Control register fields
    localparam int BRB_CTRL_BANK  = 0;
    localparam int BRB_CTRL_PAUSE = 2;
    localparam int BRB_CTRL_COLD  = 3;
    localparam int BRB_CTRL_WARM  = 4;
    // Command register bits
    localparam int BRB_CMD_IALL   = 0;
    localparam int BRB_CMD_INJ    = 1;

    localparam logic [1:0] BRB_RESP_OKAY   = 2'h0;
    localparam logic [1:0] BRB_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [31:0] src;
        logic [31:0] tgt;
        logic [31:0] inf;
    } brb_rec_t;

    typedef enum logic [2:0] {
        BRB_W_IDLE = 3'b001,
        BRB_W_DO   = 3'b010,
        BRB_W_RESP = 3'b100
    } brb_wst_t;

endpackage : brb_pkg

// ===== rtl/brb_store.sv
// Branch record store with AXI4-Lite register access.
// Assumes the core gives retire-ordered capture pulses and a prohibited level.
//
// Summary of operation
// - Capacity fixed, reported in ID register field
// - Bank select chooses entries 0-31 or 32-63
// - Index zero holds youngest record
// - Full store drops oldest on new record
// - Valid entries contiguous from index zero
// - Valid when info validity field nonzero
// - Capture indirectly writes entry registers
// - Invalidate-all marks every entry invalid
// - Invalidate removes records before earlier sync
// - Invalidate spares records after later sync
// - Invalidating entry invalidates all older ones
// - Invalid entry stays until overwritten
// - Out-of-capacity reads return zero
// - Unpaused captures form one continuous block
// - Uncapturable record invalidates whole store
// - Inject in prohibited region inserts youngest
// - Inject elsewhere may or may not insert
// - Inject uses earlier staging writes only
// - Staging contents undefined after inject
// - Cold and warm enables clear on resets
// - Revised version keeps controls across warm reset
// - Paused flag stops record generation
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
module brb_store (
    // Clock and reset
    input  wire  logic               aclk,
    input  wire  logic               aresetn,
    input  wire  logic               clk_en,
    input  wire  logic               warm_resetn,
    // Core record stream
    input  wire  logic               rec_capture,
    input  wire  brb_pkg::brb_rec_t  rec_data,
    input  wire  logic               rec_lost,
    input  wire  logic               rec_prohibited,
    // AXI4-Lite write
    input  wire  logic [11:0]        s_awaddr,
    input  wire  logic               s_awvalid,
    output logic                     s_awready,
    input  wire  logic [31:0]        s_wdata,
    input  wire  logic [3:0]         s_wstrb,
    input  wire  logic               s_wvalid,
    output logic                     s_wready,
    output logic [1:0]               s_bresp,
    output logic                     s_bvalid,
    input  wire  logic               s_bready,
    // AXI4-Lite read
    input  wire  logic [11:0]        s_araddr,
    input  wire  logic               s_arvalid,
    output logic                     s_arready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    output logic                     s_rvalid,
    input  wire  logic               s_rready,
    // Status
    output logic                     recording_paused_flag,
    output logic                     top_level_record_cold_enable,
    output logic                     top_level_record_warm_enable
);
    import brb_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    brb_rec_t                mem_q [BRB_DEPTH];
    logic                    prohib_s1_q;
    logic                    prohib_q;
    logic                    warm_s1_q;
    logic                    warm_s2_q;
    logic                    warm_q;
    logic [1:0]              record_bank_select;
    brb_rec_t                stage_q;
    brb_wst_t                wst_q;
    logic                    aw_got_q;
    logic                    w_got_q;
    logic [11:0]             awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    bad_w;
    logic                    do_wr;
    logic                    wr_ctrl;
    logic                    wr_cmd;
    logic                    iall;
    logic                    inject;
    logic                    capture;
    logic                    push;
    brb_rec_t                push_rec;
    logic [BRB_IDX_W:0]      count_q;
    logic [31:0]             rd_d;
    logic                    rd_ok;
    logic [BRB_IDX_W:0]      rd_idx;
    logic [1:0]              rd_word;
    logic [11:0]             rd_off;

    // The prohibited level comes from another clock region of the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prohib_s1_q <= 1'b1;
            prohib_q    <= 1'b1;
            warm_s1_q   <= 1'b0;
            warm_s2_q   <= 1'b0;
            warm_q      <= 1'b0;
        end else if (clk_en) begin
            prohib_s1_q <= rec_prohibited;
            prohib_q    <= prohib_s1_q;
            warm_s1_q   <= warm_resetn;
            warm_s2_q   <= warm_s1_q;
            warm_q      <= warm_s2_q;
        end
    end

    // ********************************************************************
    // AXI4-Lite write channel
    // ********************************************************************
    assign do_wr   = (wst_q == BRB_W_DO);
    assign wr_ctrl = do_wr && (awaddr_q == BRB_A_CTRL) && wstrb_q[0];
    assign wr_cmd  = do_wr && (awaddr_q == BRB_A_CMD) && wstrb_q[0];
    assign bad_w   = !(awaddr_q == BRB_A_CTRL || awaddr_q == BRB_A_CMD ||
                       awaddr_q == BRB_A_STG_SRC || awaddr_q == BRB_A_STG_TGT ||
                       awaddr_q == BRB_A_STG_INF);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q     <= BRB_W_IDLE;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= BRB_RESP_OKAY;
        end else if (clk_en) begin
            case (wst_q)
                BRB_W_IDLE: begin
                    s_awready <= !aw_got_q && !(s_awvalid && s_awready);
                    s_wready  <= !w_got_q && !(s_wvalid && s_wready);
                    if (s_awvalid && s_awready) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= s_awaddr;
                    end
                    if (s_wvalid && s_wready) begin
                        w_got_q <= 1'b1;
                        wdata_q <= s_wdata;
                        wstrb_q <= s_wstrb;
                    end
                    if ((aw_got_q || (s_awvalid && s_awready)) &&
                        (w_got_q || (s_wvalid && s_wready))) begin
                        s_awready <= 1'b0;
                        s_wready  <= 1'b0;
                        wst_q     <= BRB_W_DO;
                    end
                end
                BRB_W_DO: begin
                    aw_got_q <= 1'b0;
                    w_got_q  <= 1'b0;
                    s_bvalid <= 1'b1;
                    s_bresp  <= bad_w ? BRB_RESP_SLVERR : BRB_RESP_OKAY;
                    wst_q    <= BRB_W_RESP;
                end
                BRB_W_RESP: begin
                    if (s_bready) begin
                        s_bvalid  <= 1'b0;
                        s_awready <= 1'b1;
                        s_wready  <= 1'b1;
                        wst_q     <= BRB_W_IDLE;
                    end
                end
                default: begin
                    wst_q <= BRB_W_IDLE;
                end
            endcase
        end
    end

    // ********************************************************************
    // Control and staging registers
    // ********************************************************************
    // Cold enable resets only by aresetn, the cold reset; warm enable clears on either reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            top_level_record_cold_enable <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            top_level_record_cold_enable <= wdata_q[BRB_CTRL_COLD];
        end
    end

    // Warm clear waits on clk_en too, so a frozen block keeps every bit except under aresetn, which acts without clk_en
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            top_level_record_warm_enable <= 1'b0;
        end else if (clk_en) begin
            if (!warm_q) begin
                top_level_record_warm_enable <= 1'b0;
            end else if (wr_ctrl) begin
                top_level_record_warm_enable <= wdata_q[BRB_CTRL_WARM];
            end
        end
    end

    // Bank and pause hold through warm reset; defined after cold reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            record_bank_select    <= 2'h0;
            recording_paused_flag <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            record_bank_select    <= wdata_q[BRB_CTRL_BANK +: 2];
            recording_paused_flag <= wdata_q[BRB_CTRL_PAUSE];
        end
    end

    // Writes complete in order before a later command, so inject sees them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_q <= '0;
        end else if (clk_en && do_wr && wstrb_q[0]) begin
            if (awaddr_q == BRB_A_STG_SRC) stage_q.src <= wdata_q;
            if (awaddr_q == BRB_A_STG_TGT) stage_q.tgt <= wdata_q;
            if (awaddr_q == BRB_A_STG_INF) stage_q.inf <= wdata_q;
        end
    end

    // ********************************************************************
    // Record store: shift register, youngest at index zero
    // ********************************************************************
    assign iall    = wr_cmd && wdata_q[BRB_CMD_IALL];
    // Inject honoured only when prohibited; elsewhere dropped
    assign inject  = wr_cmd && wdata_q[BRB_CMD_INJ] && prohib_q;
    // Capture only when unpaused and allowed
    assign capture = rec_capture && !recording_paused_flag && !prohib_q && !rec_lost &&
                     (rec_data.inf[BRB_VALID_LSB +: 2] != BRB_VALID_NONE);
    assign push     = capture || inject;
    assign push_rec = capture ? rec_data : stage_q;

    // Store count counts every push up to BRB_DEPTH, whatever the validity field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else if (clk_en) begin
            if (iall || rec_lost) begin
                count_q <= '0;
            end else if (push && count_q != (BRB_IDX_W + 1)'(BRB_DEPTH)) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Invalidate clears all at once, so older entries follow
    // Commands act in order: records before take effect, later ones survive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < BRB_DEPTH; i++) mem_q[i] <= '0;
        end else if (clk_en) begin
            if (iall || rec_lost) begin
                for (int i = 0; i < BRB_DEPTH; i++) mem_q[i] <= '0;
            end else if (push) begin
                mem_q[0] <= push_rec;
                for (int i = 1; i < BRB_DEPTH; i++) begin
                    mem_q[i] <= mem_q[i-1];
                end
            end
        end
    end

    // ********************************************************************
    // AXI4-Lite read channel
    // ********************************************************************
    always_comb begin
        rd_d    = 32'h0000_0000;
        rd_ok   = 1'b1;
        rd_off  = s_araddr - BRB_A_WIN;
        rd_word = rd_off[3:2];
        rd_idx  = {1'b0, record_bank_select[0], rd_off[8:4]};
        if (s_araddr >= BRB_A_WIN && s_araddr < BRB_A_WIN_END) begin
            // Bank select 2 or 3 is out of range and reads zero, as does the unused word
            if (record_bank_select[1] == 1'b0 && rd_idx < (BRB_IDX_W + 1)'(BRB_DEPTH)) begin
                case (rd_word)
                    2'h0:    rd_d = mem_q[rd_idx[BRB_IDX_W-1:0]].src;
                    2'h1:    rd_d = mem_q[rd_idx[BRB_IDX_W-1:0]].tgt;
                    2'h2:    rd_d = mem_q[rd_idx[BRB_IDX_W-1:0]].inf;
                    default: rd_d = 32'h0000_0000;
                endcase
            end
        end else begin
            case (s_araddr)
                BRB_A_ID:   rd_d = {24'h00_0000, BRB_CAP_CODE};
                BRB_A_CTRL: rd_d = {27'h000_0000, top_level_record_warm_enable,
                                    top_level_record_cold_enable, recording_paused_flag,
                                    record_bank_select};
                BRB_A_STAT: rd_d = {25'h000_0000, count_q};
                BRB_A_STG_SRC, BRB_A_STG_TGT, BRB_A_STG_INF, BRB_A_CMD:
                            rd_d = 32'h0000_0000;
                default:    rd_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= BRB_RESP_OKAY;
        end else if (clk_en) begin
            if (s_rvalid) begin
                if (s_rready) begin
                    s_rvalid  <= 1'b0;
                    s_arready <= 1'b1;
                end
            end else if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid  <= 1'b1;
                s_rdata   <= rd_d;
                s_rresp   <= rd_ok ? BRB_RESP_OKAY : BRB_RESP_SLVERR;
            end else begin
                s_arready <= 1'b1;
            end
        end
    end

endmodule : brb_store

// ===== verification/brb_core_model.sv
// Core-side stand-in: turns bench requests into record, lost and prohibited signals.
// Assumes requests change by non-blocking assignment at the rising edge of aclk.
module brb_core_model (
    // Clock and bench requests
    input  wire  logic              aclk,
    input  wire  logic              cap_req,
    input  wire  logic [7:0]        cap_seed,
    input  wire  logic              lost_req,
    input  wire  logic              proh_req,
    // Record stream
    output brb_pkg::brb_rec_t       rec_data,
    output logic                    rec_capture,
    output logic                    rec_lost,
    output logic                    rec_prohibited
);
    timeunit 1ns;
    timeprecision 1ps;
    import brb_pkg::*;
    logic [31:0] tick = 32'h0;

    // Data lines churn between records, so a store that ignores the pulse loads junk
    always_ff @(posedge aclk) begin
        tick           <= tick + 32'h1;
        rec_capture    <= cap_req;
        rec_lost       <= lost_req;
        rec_prohibited <= proh_req;
        if (cap_req) begin
            rec_data <= '{32'h1000_0000 | 32'(cap_seed), 32'h2000_0000, 32'h1};
        end else begin
            rec_data <= '{tick, ~tick, tick};
        end
    end
endmodule : brb_core_model

// ===== verification/brb_store_chk.sv
// Checker for the branch record store: bus timing, enables and pause control.
// Assumes it is bound to brb_store and sees only that module's ports.
module brb_store_chk (
    // Clock and resets
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        warm_resetn,
    // Register bus
    input wire logic [11:0] s_awaddr,
    input wire logic        s_awvalid,
    input wire logic        s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0]  s_wstrb,
    input wire logic        s_wvalid,
    input wire logic        s_wready,
    input wire logic        s_bvalid,
    input wire logic        s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic        s_arvalid,
    input wire logic        s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic        s_rvalid,
    input wire logic        s_rready,
    // Status
    input wire logic        recording_paused_flag,
    input wire logic        top_level_record_cold_enable,
    input wire logic        top_level_record_warm_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    import brb_pkg::*;
    logic [11:0] rd_addr_q;
    logic        pause_q;
    logic        ctrl_wr;
    assign ctrl_wr = s_awvalid && s_awready && s_wvalid && s_wready && s_wstrb[0]
                     && s_awaddr == BRB_A_CTRL;
    always_ff @(posedge aclk) begin
        if (s_arvalid && s_arready) rd_addr_q <= s_araddr;
    end
    always_ff @(posedge aclk) begin
        if (ctrl_wr) pause_q <= s_wdata[BRB_CTRL_PAUSE];
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_id_cap;
        s_rvalid && rd_addr_q == BRB_A_ID |-> s_rdata[7:0] == BRB_CAP_CODE; endproperty
    a_id_cap: assert property (p_id_cap) else $error("capacity code wrong");
    property p_rd_ans; s_arvalid && s_arready |-> ##[1:2] s_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_rd_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_wr_ans;
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:3] s_bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_b_hold; s_bvalid && !s_bready |=> s_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_pause; ctrl_wr |-> ##[1:3] recording_paused_flag == pause_q; endproperty
    a_pause: assert property (p_pause) else $error("paused flag wrong");
    property p_warm; !warm_resetn [*5] |-> !top_level_record_warm_enable; endproperty
    a_warm: assert property (p_warm) else $error("warm enable kept");
    property p_cold;
        $rose(aresetn) |-> !top_level_record_cold_enable && !s_bvalid && !s_rvalid; endproperty
    a_cold: assert property (p_cold) else $error("cold enable kept");

    c_pause: cover property (ctrl_wr && s_wdata[BRB_CTRL_PAUSE]);
    c_read:  cover property (s_rvalid && s_rready);
    c_warm:  cover property ($fell(top_level_record_warm_enable));
endmodule : brb_store_chk

bind brb_store brb_store_chk chk (.*);

// ===== verification/brb_store_bench.sv
// Self-checking bench for the branch record store, driven over AXI4-Lite.
// Assumes brb_pkg, brb_store, brb_core_model and the bound checker are compiled first.
module brb_store_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import brb_pkg::*;
    logic        aclk, aresetn, warm_resetn, clk_en, rec_capture, rec_lost, rec_prohibited;
    brb_rec_t    rec_data;
    logic [11:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, recording_paused_flag;
    logic        top_level_record_cold_enable, top_level_record_warm_enable;
    logic        cap_req, lost_req, proh_req;
    logic [7:0]  cap_seed;
    int          fails, samples_checked;
    typedef struct {logic [2:0] op; logic [11:0] a; logic [31:0] d;} brb_row_t;
    brb_row_t    rows[$];
    localparam logic [2:0] OP_WR = 3'h0, OP_RD = 3'h1, OP_BY = 3'h2;
    localparam logic [2:0] OP_CAP = 3'h3, OP_PRH = 3'h4, OP_UNM = 3'h5;

    brb_store dut (.*);
    brb_core_model core (.aclk(aclk), .cap_req(cap_req), .cap_seed(cap_seed),
        .lost_req(lost_req), .proh_req(proh_req), .rec_data(rec_data),
        .rec_capture(rec_capture), .rec_lost(rec_lost), .rec_prohibited(rec_prohibited));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    function automatic logic [31:0] src_of(input int s);
        return 32'h1000_0000 | 32'(s);
    endfunction : src_of
    function automatic void r(input logic [2:0] op, input logic [11:0] a, input logic [31:0] d);
        rows.push_back('{op, a, d});
    endfunction : r
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // Both channels offered together; each dropped on its own acceptance
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_awaddr  <= a;
        s_wdata   <= d;
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid && n < 64);
        if (!s_bvalid) fails++;
        s_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        {s_arvalid, s_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid && n < 64);
        if (!s_rvalid) fails++;
        d  = s_rdata;
        rs = s_rresp;
        s_rready <= 1'b0;
    endtask : rd
    task automatic cap(input int first, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            @(posedge aclk);
            cap_req  <= 1'b1;
            cap_seed <= 8'(first + i);
        end
        @(posedge aclk);
        cap_req <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : cap

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        complete_run();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  rs;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, cap_req, lost_req} = '0;
        {cap_seed, s_awaddr, s_araddr, s_wdata} = '0;
        {warm_resetn, clk_en, proh_req} = 3'h7;
        s_wstrb = 4'hF;
        fails = 0;
        samples_checked = 0;
        r(OP_WR, BRB_A_CMD, 32'h1);
        r(OP_PRH, 12'h0, 32'h0);   r(OP_BY, BRB_A_ID, 32'h40);
        r(OP_RD, BRB_A_STAT, 32'h0);  r(OP_WR, BRB_A_CTRL, 32'h0);
        r(OP_CAP, 12'h0, 32'h1);      r(OP_CAP, 12'h0, 32'h2);   r(OP_RD, BRB_A_STAT, 32'h2);
        r(OP_RD, 12'h400, src_of(2)); r(OP_RD, 12'h410, src_of(1));
        r(OP_RD, 12'h408, 32'h1);     r(OP_RD, 12'h428, 32'h0);  r(OP_WR, BRB_A_CTRL, 32'h4);
        r(OP_CAP, 12'h0, 32'h3);      r(OP_RD, BRB_A_STAT, 32'h2);
        r(OP_WR, BRB_A_CTRL, 32'h0);  r(OP_PRH, 12'h0, 32'h1);
        r(OP_WR, BRB_A_STG_SRC, 32'hABCD_0001); r(OP_WR, BRB_A_STG_TGT, 32'hABCD_0002);
        r(OP_WR, BRB_A_STG_INF, 32'h1); r(OP_WR, BRB_A_CMD, 32'h2);
        r(OP_WR, BRB_A_STG_SRC, 32'h5555_0000); r(OP_RD, 12'h400, 32'hABCD_0001);
        r(OP_RD, 12'h410, src_of(2)); r(OP_RD, BRB_A_STAT, 32'h3); r(OP_PRH, 12'h0, 32'h0);
        r(OP_WR, BRB_A_CMD, 32'h1);   r(OP_RD, BRB_A_STAT, 32'h0);
        r(OP_RD, 12'h408, 32'h0);     r(OP_UNM, 12'h100, 32'h0);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            case (rows[i].op)
                OP_WR: wr(rows[i].a, rows[i].d);
                OP_CAP: cap(int'(rows[i].d), 1);
                OP_PRH: proh_req <= rows[i].d[0];
                default: begin
                    rd(rows[i].a, d, rs);
                    if (rows[i].op == OP_UNM) chk(32'(rs), 32'(BRB_RESP_SLVERR));
                    else if (rows[i].op == OP_BY) chk({24'h0, d[7:0]}, rows[i].d);
                    else chk(d, rows[i].d);
                end
            endcase
        end
        // Back-to-back captures overfill the store by one
        cap(0, 65);
        rd(BRB_A_STAT, d, rs);
        chk(d, 32'h40);
        rd(BRB_A_WIN, d, rs);
        chk(d, src_of(64));
        wr(BRB_A_CTRL, 32'h1);
        rd(BRB_A_WIN, d, rs);
        chk(d, src_of(32));
        rd(12'h5F0, d, rs);
        chk(d, src_of(1));
        wr(BRB_A_CTRL, 32'h2);
        rd(BRB_A_WIN, d, rs);
        chk(d, 32'h0);
        @(posedge aclk);
        lost_req <= 1'b1;
        @(posedge aclk);
        lost_req <= 1'b0;
        rd(BRB_A_STAT, d, rs);
        chk(d, 32'h0);
        // A capture while clk_en is low must leave the emptied store untouched
        clk_en <= 1'b0;
        cap(9, 1);
        clk_en <= 1'b1;
        rd(BRB_A_STAT, d, rs);
        chk(d, 32'h0);
        wr(12'h100, 32'h0);
        chk(32'(s_bresp), 32'(BRB_RESP_SLVERR));
        wr(BRB_A_CTRL, 32'h18);
        @(negedge aclk);
        chk({30'h0, top_level_record_cold_enable, top_level_record_warm_enable}, 32'h3);
        @(posedge aclk);
        warm_resetn <= 1'b0;
        repeat (6) @(posedge aclk);
        warm_resetn <= 1'b1;
        @(negedge aclk);
        chk({30'h0, top_level_record_cold_enable, top_level_record_warm_enable}, 32'h2);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({29'h0, recording_paused_flag, top_level_record_cold_enable,
             top_level_record_warm_enable}, 32'h0);
        complete_run();
    end
endmodule : brb_store_bench
